/* File: design/ppm_pkg.sv */
// package: constants, register map and carrier types of the pulse meter
package ppm_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned PPM_CLK_FREQ_MHZ = 100;
    localparam int unsigned PPM_CLK_PERIOD_NS = 1000 / PPM_CLK_FREQ_MHZ;
    localparam int unsigned PPM_EDGE_PULSE_NS = PPM_CLK_PERIOD_NS;
    localparam int unsigned PPM_EDGE_PULSE_CYCLES =
        (PPM_EDGE_PULSE_NS + PPM_CLK_PERIOD_NS - 1) / PPM_CLK_PERIOD_NS;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned PPM_AW = 8;
    localparam int unsigned PPM_DW = 32;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] PPM_OFS_CTRL = 8'h00;
    localparam logic [7:0] PPM_OFS_STOP_LIMIT = 8'h04;
    localparam logic [7:0] PPM_OFS_ACC_PULSES = 8'h08;
    localparam logic [7:0] PPM_OFS_WINDOW = 8'h0C;
    localparam logic [7:0] PPM_OFS_STATUS = 8'h10;
    localparam logic [7:0] PPM_OFS_PERIOD = 8'h14;
    localparam logic [7:0] PPM_OFS_WIDTH = 8'h18;
    localparam logic [7:0] PPM_OFS_ELAPSED = 8'h1C;
    localparam logic [7:0] PPM_OFS_ACC_TOTAL = 8'h20;
    localparam logic [7:0] PPM_OFS_PULSE_COUNT = 8'h24;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned PPM_CTRL_ACCUM_EN_BIT = 0;
    localparam int unsigned PPM_STAT_STOPPED_BIT = 0;
    localparam int unsigned PPM_STAT_LEVEL_BIT = 1;
    localparam int unsigned PPM_STAT_SEEN_BIT = 2;

    // ************************************************************
    // values after reset
    // ************************************************************
    localparam logic [31:0] PPM_RST_STOP_LIMIT = 32'h0100_0000;
    localparam logic [31:0] PPM_RST_ACC_PULSES = 32'h0000_0010;
    localparam logic [31:0] PPM_RST_WINDOW = 32'h0098_9680;
    localparam logic PPM_RST_ACCUM_EN = 1'b0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [31:0] period;
        logic [31:0] pulse_width;
        logic stopped;
    } ppm_meas_type;

    typedef struct packed {
        logic [31:0] period_total;
        logic [31:0] pulse_count;
    } ppm_accum_type;

    typedef struct packed {
        logic [PPM_AW-1:0] addr;
        logic [PPM_DW-1:0] wr_data;
        logic wr_en;
        logic rd_en;
    } ppm_bus_req_type;

endpackage : ppm_pkg

/* File: design/ppm_sync3.sv */
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ppm_sync3
    import ppm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ppm_sync_state_type;

    ppm_sync_state_type st_r;
    ppm_sync_state_type st_nxt;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // a change only counts once the two settled stages agree
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;

endmodule : ppm_sync3

`default_nettype wire

/* File: design/ppm_meter.sv */
// module: period, pulse-width and accumulating pulse meter top
`timescale 1ns/1ps
`default_nettype none

module ppm_meter
    import ppm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic measured_input,
    input wire ppm_bus_req_type bus_req,
    output logic [PPM_DW-1:0] rd_data,
    output ppm_meas_type measurement_bundle,
    output ppm_accum_type accum_bundle,
    output logic [31:0] elapsed_ticks,
    output logic rise_pulse,
    output logic fall_pulse
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic prev_lvl;
        logic rise_q;
        logic fall_q;
        logic seen;
        logic stopped;
        logic [31:0] elapsed;
        logic [31:0] period;
        logic [31:0] width;
        logic [31:0] sum;
        logic [31:0] n_pul;
        logic [31:0] total;
        logic [31:0] win_cnt;
        logic [31:0] win_pul;
        logic [31:0] pcount;
        logic accum_en;
        logic [31:0] stop_limit;
        logic [31:0] acc_pulses;
        logic [31:0] window;
        logic [PPM_DW-1:0] rdata;
    } ppm_state_type;

    ppm_state_type st_r;
    ppm_state_type st_nxt;

    logic lvl;
    logic rise;
    logic fall;
    logic [31:0] elapsed_inc;
    logic [31:0] period_now;
    logic [31:0] sum_now;
    logic [31:0] n_now;
    logic [31:0] win_inc;
    logic [31:0] win_pul_now;

    // ************************************************************
    // input synchroniser
    // ************************************************************
    ppm_sync3 u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(measured_input),
        .level(lvl)
    );

    // edges against the registered previous sample
    assign rise = lvl & ~st_r.prev_lvl;
    assign fall = ~lvl & st_r.prev_lvl;
    assign elapsed_inc = st_r.elapsed + 32'h1;
    assign period_now = elapsed_inc;
    assign sum_now = st_r.sum + period_now;
    assign n_now = st_r.n_pul + 32'h1;
    assign win_inc = st_r.win_cnt + 32'h1;
    assign win_pul_now = st_r.win_pul + {31'h0, rise};

    // ************************************************************
    // next state, one update per clock
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev_lvl = lvl;
        st_nxt.rise_q = rise;
        st_nxt.fall_q = fall;
        st_nxt.rdata = '0;

        // elapsed counter and stop detection
        if (rise) begin
            st_nxt.elapsed = '0;
            st_nxt.stopped = 1'b0;
            st_nxt.seen = 1'b1;
            // no valid period straight out of a stop or before first edge
            if (st_r.seen && !st_r.stopped) begin
                st_nxt.period = period_now;
            end
        end else if (st_r.stopped) begin
            st_nxt.elapsed = st_r.elapsed;
        end else if (elapsed_inc >= st_r.stop_limit) begin
            // >= also catches a limit lowered below the running count
            st_nxt.elapsed = st_r.stop_limit;
            st_nxt.stopped = 1'b1;
        end else begin
            st_nxt.elapsed = elapsed_inc;
        end

        if (fall && st_r.seen && !st_r.stopped) begin
            st_nxt.width = elapsed_inc;
        end

        // accumulating mode
        if (!st_r.accum_en) begin
            st_nxt.sum = '0;
            st_nxt.n_pul = '0;
            st_nxt.total = '0;
            st_nxt.win_cnt = '0;
            st_nxt.win_pul = '0;
            st_nxt.pcount = '0;
        end else begin
            if (rise && st_r.seen && !st_r.stopped) begin
                // a programmed count of zero acts as one
                if (n_now >= st_r.acc_pulses) begin
                    st_nxt.total = sum_now;
                    st_nxt.sum = '0;
                    st_nxt.n_pul = '0;
                end else begin
                    st_nxt.sum = sum_now;
                    st_nxt.n_pul = n_now;
                end
            end
            if (win_inc >= st_r.window) begin
                st_nxt.pcount = win_pul_now;
                st_nxt.win_cnt = '0;
                st_nxt.win_pul = '0;
            end else begin
                st_nxt.win_cnt = win_inc;
                st_nxt.win_pul = win_pul_now;
            end
        end

        // stopped forces every result to zero
        if (st_nxt.stopped) begin
            st_nxt.period = '0;
            st_nxt.width = '0;
            st_nxt.sum = '0;
            st_nxt.n_pul = '0;
            st_nxt.total = '0;
            st_nxt.win_pul = '0;
            st_nxt.pcount = '0;
        end

        // register writes
        if (bus_req.wr_en) begin
            case (bus_req.addr)
                PPM_OFS_CTRL: begin
                    st_nxt.accum_en =
                        bus_req.wr_data[PPM_CTRL_ACCUM_EN_BIT];
                end
                PPM_OFS_STOP_LIMIT: begin
                    st_nxt.stop_limit = bus_req.wr_data;
                end
                PPM_OFS_ACC_PULSES: begin
                    st_nxt.acc_pulses = bus_req.wr_data;
                end
                PPM_OFS_WINDOW: begin
                    st_nxt.window = bus_req.wr_data;
                end
                default: begin
                end
            endcase
        end

        // register reads, answered in the next cycle only
        if (bus_req.rd_en) begin
            case (bus_req.addr)
                PPM_OFS_CTRL: begin
                    st_nxt.rdata[PPM_CTRL_ACCUM_EN_BIT] = st_r.accum_en;
                end
                PPM_OFS_STOP_LIMIT: begin
                    st_nxt.rdata = st_r.stop_limit;
                end
                PPM_OFS_ACC_PULSES: begin
                    st_nxt.rdata = st_r.acc_pulses;
                end
                PPM_OFS_WINDOW: begin
                    st_nxt.rdata = st_r.window;
                end
                PPM_OFS_STATUS: begin
                    st_nxt.rdata[PPM_STAT_STOPPED_BIT] = st_r.stopped;
                    st_nxt.rdata[PPM_STAT_LEVEL_BIT] = st_r.prev_lvl;
                    st_nxt.rdata[PPM_STAT_SEEN_BIT] = st_r.seen;
                end
                PPM_OFS_PERIOD: begin
                    st_nxt.rdata = st_r.period;
                end
                PPM_OFS_WIDTH: begin
                    st_nxt.rdata = st_r.width;
                end
                PPM_OFS_ELAPSED: begin
                    st_nxt.rdata = st_r.elapsed;
                end
                PPM_OFS_ACC_TOTAL: begin
                    st_nxt.rdata = st_r.total;
                end
                PPM_OFS_PULSE_COUNT: begin
                    st_nxt.rdata = st_r.pcount;
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.accum_en <= PPM_RST_ACCUM_EN;
            st_r.stop_limit <= PPM_RST_STOP_LIMIT;
            st_r.acc_pulses <= PPM_RST_ACC_PULSES;
            st_r.window <= PPM_RST_WINDOW;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rd_data = st_r.rdata;
    assign measurement_bundle.period = st_r.period;
    assign measurement_bundle.pulse_width = st_r.width;
    assign measurement_bundle.stopped = st_r.stopped;
    assign accum_bundle.period_total = st_r.total;
    assign accum_bundle.pulse_count = st_r.pcount;
    assign elapsed_ticks = st_r.elapsed;
    assign rise_pulse = st_r.rise_q;
    assign fall_pulse = st_r.fall_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking ppm_cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_valid_rise;
        rise && st_r.seen && !st_r.stopped;
    endsequence

    sequence s_valid_fall;
        // a fall in the stopping cycle is zeroed, not latched
        fall && st_r.seen && !st_r.stopped && !st_nxt.stopped;
    endsequence

    sequence s_run_tick;
        // the release edge still loads reset values, so it is no tick
        !sys_rst && !rise && !st_r.stopped
            && (elapsed_inc < st_r.stop_limit);
    endsequence

    sequence s_acc_close;
        st_r.accum_en && rise && st_r.seen && !st_r.stopped
            && (n_now >= st_r.acc_pulses);
    endsequence

    sequence s_win_close;
        st_r.accum_en && (win_inc >= st_r.window) && !st_nxt.stopped;
    endsequence

    AST_RISE_CAUSE: assert property (
        rise_pulse |-> $past(lvl) && !$past(st_r.prev_lvl))
        else $error("rise pulse without a rising edge");

    AST_RISE_ONE: assert property (
        rise_pulse |=> !rise_pulse)
        else $error("rise pulse longer than one cycle");

    AST_FALL_CAUSE: assert property (
        fall |=> fall_pulse ##1 !fall_pulse)
        else $error("fall pulse not exactly one cycle");

    AST_PERIOD_LATCH: assert property (
        s_valid_rise |=> measurement_bundle.period == $past(elapsed_inc))
        else $error("period not latched on rising edge");

    AST_WIDTH_LATCH: assert property (
        s_valid_fall |=> measurement_bundle.pulse_width == $past(elapsed_inc))
        else $error("pulse width not latched on falling edge");

    AST_ELAPSED_RUN: assert property (
        s_run_tick |=> elapsed_ticks == $past(elapsed_ticks) + 32'h1)
        else $error("elapsed count did not advance");

    AST_STOP_ZERO: assert property (
        measurement_bundle.stopped |-> measurement_bundle.period == '0
            && measurement_bundle.pulse_width == '0
            && accum_bundle.period_total == '0
            && accum_bundle.pulse_count == '0)
        else $error("results not zero while stopped");

    AST_STOP_SET: assert property (
        (!rise && !st_r.stopped && elapsed_inc >= st_r.stop_limit)
            |=> measurement_bundle.stopped
            && elapsed_ticks == $past(st_r.stop_limit))
        else $error("stop limit reached without stopping");

    AST_STOP_HOLD: assert property (
        (st_r.stopped && !rise) |=> st_r.stopped
            && elapsed_ticks == $past(elapsed_ticks))
        else $error("stopped state not held");

    AST_RESTART: assert property (
        rise |=> !measurement_bundle.stopped && elapsed_ticks == '0)
        else $error("rising edge did not restart counting");

    AST_RDATA_IDLE: assert property (
        !bus_req.rd_en |=> rd_data == '0)
        else $error("read data outside the answer cycle");

    AST_ACC_TOTAL: assert property (
        s_acc_close |=> accum_bundle.period_total == $past(sum_now))
        else $error("period total not taken after the programmed pulses");

    AST_WIN_COUNT: assert property (
        s_win_close |=> accum_bundle.pulse_count == $past(win_pul_now))
        else $error("pulse count not taken at the end of the window");

    AST_ACC_OFF: assert property (
        !st_r.accum_en |=> accum_bundle.period_total == '0
            && accum_bundle.pulse_count == '0)
        else $error("accumulators not cleared while disabled");

endmodule : ppm_meter

`default_nettype wire

/* File: dv/ppm_pulse_src.sv */
// partner model: external digital pulse source on the measured input
`timescale 1ns/1ps
`default_nettype none

module ppm_pulse_src (
    input wire logic sys_clk,
    output logic pulse_out
);
    // ************************************************************
    // pulse train generator
    // ************************************************************
    // idle low: the sensor line is pulled low between trains
    initial pulse_out = 1'b0;

    // levels held >=3 cycles so the synchroniser sees every edge
    task automatic burst(input int hi, input int lo, input int n);
        for (int i = 0; i < n; i++) begin
            pulse_out <= 1'b1;
            repeat (hi) @(posedge sys_clk);
            pulse_out <= 1'b0;
            repeat (lo) @(posedge sys_clk);
        end
    endtask : burst
endmodule : ppm_pulse_src

`default_nettype wire

/* File: dv/test_ppm_meter.sv */
// testbench: register access and pulse measurement tests of the meter
`timescale 1ns/1ps
`default_nettype none

module test_ppm_meter
    import ppm_pkg::*;
;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic measured_input;
    ppm_bus_req_type bus_req = '0;
    logic [PPM_DW-1:0] rd_data;
    ppm_meas_type measurement_bundle;
    ppm_accum_type accum_bundle;
    logic [31:0] elapsed_ticks;
    logic rise_pulse;
    logic fall_pulse;
    int err_total = 0;
    int compares = 0;
    int n_rise = 0;
    int n_fall = 0;
    int r0;
    int f0;
    logic [31:0] d;

    always #5 sys_clk = ~sys_clk;

    ppm_meter DUT (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .measured_input(measured_input),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .measurement_bundle(measurement_bundle),
        .accum_bundle(accum_bundle),
        .elapsed_ticks(elapsed_ticks),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse)
    );

    ppm_pulse_src src (
        .sys_clk(sys_clk),
        .pulse_out(measured_input)
    );

    // counts high cycles, so a stretched pulse shows as an extra edge
    always @(posedge sys_clk) begin
        if (rise_pulse === 1'b1) n_rise <= n_rise + 1;
        if (fall_pulse === 1'b1) n_fall <= n_fall + 1;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic results;
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // all bus tasks start and end just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus_req <= '{addr: a, wr_data: v, wr_en: 1'b1, rd_en: 1'b0};
        @(posedge sys_clk);
        bus_req <= '0;
        @(posedge sys_clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus_req <= '{addr: a, wr_data: 32'h0, wr_en: 1'b0, rd_en: 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 v = rd_data;
        @(posedge sys_clk);
        #1;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rchk

    // sel 0 waits for a rise pulse, sel 1 for the stopped flag
    task automatic wait_for(input int sel, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge sys_clk);
            #1;
            if (sel == 0 && rise_pulse === 1'b1) return;
            if (sel == 1 && measurement_bundle.stopped === 1'b1) return;
        end
        err_total++;
        $display("CHECK FAILED t=%0t wait sel=%h ran out", $time, sel);
        results();
    endtask : wait_for

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        rchk(PPM_OFS_CTRL, 32'h0);
        rchk(PPM_OFS_STOP_LIMIT, PPM_RST_STOP_LIMIT);
        rchk(PPM_OFS_ACC_PULSES, PPM_RST_ACC_PULSES);
        rchk(PPM_OFS_WINDOW, PPM_RST_WINDOW);
        rchk(8'h30, 32'h0);
        wr(PPM_OFS_PERIOD, 32'h0000_0055);
        rchk(PPM_OFS_PERIOD, 32'h0);
        wr(PPM_OFS_STOP_LIMIT, 32'h0000_00C8);
        rchk(PPM_OFS_STOP_LIMIT, 32'h0000_00C8);
        $display("test registers done");

        r0 = n_rise;
        f0 = n_fall;
        fork
            src.burst(5, 7, 6);
            begin
                wait_for(0, 100);
                chk(elapsed_ticks, 32'h0);
                repeat (5) @(posedge sys_clk);
                #1 chk(elapsed_ticks, 32'h5);
            end
        join
        chk(measurement_bundle.period, 32'hC);
        chk(measurement_bundle.pulse_width, 32'h5);
        chk(32'(n_rise - r0), 32'h6);
        chk(32'(n_fall - f0), 32'h6);
        rchk(PPM_OFS_PERIOD, 32'hC);
        rchk(PPM_OFS_WIDTH, 32'h5);
        $display("test basic done");

        wait_for(1, 400);
        chk(elapsed_ticks, 32'hC8);
        chk(measurement_bundle.period, 32'h0);
        chk(measurement_bundle.pulse_width, 32'h0);
        rd(PPM_OFS_STATUS, d);
        chk(d, 32'h5);
        rchk(PPM_OFS_ELAPSED, 32'hC8);
        fork
            src.burst(5, 7, 3);
            begin
                wait_for(0, 100);
                chk({31'h0, measurement_bundle.stopped}, 32'h0);
                chk(measurement_bundle.period, 32'h0);
                chk(elapsed_ticks, 32'h0);
            end
        join
        chk(measurement_bundle.period, 32'hC);
        $display("test stop done");

        wr(PPM_OFS_CTRL, 32'h1);
        wr(PPM_OFS_ACC_PULSES, 32'h4);
        wr(PPM_OFS_WINDOW, 32'h0000_0064);
        src.burst(5, 5, 30);
        chk(accum_bundle.period_total, 32'h28);
        chk(accum_bundle.pulse_count, 32'hA);
        rchk(PPM_OFS_ACC_TOTAL, 32'h28);
        rchk(PPM_OFS_PULSE_COUNT, 32'hA);
        wait_for(1, 400);
        chk(accum_bundle.period_total, 32'h0);
        chk(accum_bundle.pulse_count, 32'h0);
        chk(measurement_bundle.period, 32'h0);
        rchk(PPM_OFS_ACC_TOTAL, 32'h0);
        $display("test accumulate done");

        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1 chk(elapsed_ticks, 32'h1);
        chk({31'h0, measurement_bundle.stopped}, 32'h0);
        rchk(PPM_OFS_CTRL, {31'h0, PPM_RST_ACCUM_EN});
        rchk(PPM_OFS_STOP_LIMIT, PPM_RST_STOP_LIMIT);
        rchk(PPM_OFS_STATUS, 32'h0);
        $display("test reset done");
        results();
    end
endmodule : test_ppm_meter

`default_nettype wire
